// ==== logic/ffh_pkg.sv ====
// constants, types and timing for the fall-through fifo host controller
// assumes a single 25 MHz clock and synchronous device flag inputs
// Contract
// - writer lowers shift-in after input-ready drops
// - held shift-in accepted when space appears
// - reader lowers shift-out after auto-unload
package ffh_pkg;

    // =====================================================
    // sizes
    localparam int WORD_W = 9;
    localparam int FIFO_DEPTH = 64;

    // =====================================================
    // timing, in ns as specified, and cycles derived from it
    localparam int CLK_PERIOD_NS = 40;
    localparam int T_SI_WIDTH_NS = 12;
    localparam int T_SO_WIDTH_NS = 15;
    localparam int T_MR_LOW_NS = 18;
    localparam int T_MR_REMOVAL_NS = 18;
    localparam int T_DATA_HOLD_NS = 30;

    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int SI_WIDTH_CYC = ns_to_cyc(T_SI_WIDTH_NS);
    localparam int SO_WIDTH_CYC = ns_to_cyc(T_SO_WIDTH_NS);
    localparam int MR_LOW_CYC = ns_to_cyc(T_MR_LOW_NS);
    localparam int MR_REMOVAL_CYC = ns_to_cyc(T_MR_REMOVAL_NS);
    localparam int DATA_HOLD_CYC = ns_to_cyc(T_DATA_HOLD_NS);
    localparam int CNT_W = 4;

    // =====================================================
    // types
    typedef struct packed {
        logic strobe;
        logic [WORD_W-1:0] data;
    } ffh_push_s;

    typedef enum logic [1:0] {
        W_IDLE,
        W_HIGH,
        W_LOW
    } ffh_wstate_e;

    typedef enum logic [1:0] {
        R_IDLE,
        R_HIGH,
        R_LOW
    } ffh_rstate_e;

    typedef enum logic [1:0] {
        C_ASSERT,
        C_REMOVE,
        C_RUN
    } ffh_cstate_e;

endpackage

// ==== logic/ffh_buf2.sv ====
// two-entry buffer with valid/ready on both sides
// assumes one clock; head entry and valid come straight from flops
module ffh_buf2
    import ffh_pkg::*;
#(
    parameter int W = WORD_W
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    logic v0;
    logic v1;
    logic [W-1:0] d0;
    logic [W-1:0] d1;
    logic next_v0;
    logic next_v1;
    logic [W-1:0] next_d0;
    logic [W-1:0] next_d1;
    logic push;
    logic pop;

    assign in_ready = ~v1;
    assign out_valid = v0;
    assign out_data = d0;

    always_comb
    begin
        push = in_valid & ~v1;
        pop = v0 & out_ready;
        next_v0 = v0;
        next_v1 = v1;
        next_d0 = d0;
        next_d1 = d1;
        if (pop)
        begin
            next_v0 = v1;
            next_d0 = d1;
            next_v1 = 1'b0;
        end
        if (push)
        begin
            if (!next_v0)
            begin
                next_v0 = 1'b1;
                next_d0 = in_data;
            end
            else
            begin
                next_v1 = 1'b1;
                next_d1 = in_data;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            v0 <= 1'b0;
            v1 <= 1'b0;
            d0 <= '0;
            d1 <= '0;
        end
        else
        begin
            v0 <= next_v0;
            v1 <= next_v1;
            d0 <= next_d0;
            d1 <= next_d1;
        end
    end

endmodule

// ==== logic/ffh_host.sv ====
// host controller for a 64 x 9 fall-through fifo driven by strobes and flags
// assumes device flags and output word are synchronous to REF_CLK
module ffh_host
    import ffh_pkg::*;
#(
    parameter int W = WORD_W
)
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // user control
    input wire logic CLEAR_REQ,
    output logic CLEAR_BUSY,
    // user write stream
    input wire logic WR_VALID,
    output logic WR_READY,
    input wire logic [W-1:0] WR_DATA,
    // user read stream
    output logic RD_VALID,
    input wire logic RD_READY,
    output logic [W-1:0] RD_DATA,
    // device input side
    output logic SHIFT_IN,
    output logic [W-1:0] WRITE_WORD_IN,
    input wire logic INPUT_READY,
    // device output side
    output logic SHIFT_OUT,
    input wire logic OUTPUT_READY_FLAG,
    input wire logic [W-1:0] READ_WORD_OUT,
    // device clear
    output logic MASTER_CLEAR_N
);

    // =====================================================
    // master clear sequencer
    ffh_cstate_e c_state;
    ffh_cstate_e next_c_state;
    logic [CNT_W-1:0] c_cnt;
    logic [CNT_W-1:0] next_c_cnt;
    logic next_mclr_n;
    logic next_clear_busy;
    logic running;

    assign running = (c_state == C_RUN);

    always_comb
    begin
        next_c_state = c_state;
        next_c_cnt = c_cnt;
        case (c_state)
            C_ASSERT:
            begin
                if (c_cnt == CNT_W'(MR_LOW_CYC - 1))
                begin
                    next_c_state = C_REMOVE;
                    next_c_cnt = '0;
                end
                else
                begin
                    next_c_cnt = c_cnt + 1'b1;
                end
            end
            C_REMOVE:
            begin
                if (c_cnt == CNT_W'(MR_REMOVAL_CYC - 1))
                begin
                    next_c_state = C_RUN;
                    next_c_cnt = '0;
                end
                else
                begin
                    next_c_cnt = c_cnt + 1'b1;
                end
            end
            default:
            begin
                if (CLEAR_REQ)
                begin
                    next_c_state = C_ASSERT;
                    next_c_cnt = '0;
                end
            end
        endcase
        next_mclr_n = (next_c_state != C_ASSERT);
        next_clear_busy = (next_c_state != C_RUN);
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            c_state <= C_ASSERT;
            c_cnt <= '0;
            MASTER_CLEAR_N <= 1'b0;
            CLEAR_BUSY <= 1'b1;
        end
        else
        begin
            c_state <= next_c_state;
            c_cnt <= next_c_cnt;
            MASTER_CLEAR_N <= next_mclr_n;
            CLEAR_BUSY <= next_clear_busy;
        end
    end

    // =====================================================
    // write strobe sequencer
    ffh_wstate_e w_state;
    ffh_wstate_e next_w_state;
    logic [CNT_W-1:0] w_cnt;
    logic [CNT_W-1:0] next_w_cnt;
    ffh_push_s w_pins;
    ffh_push_s next_w_pins;
    logic next_wr_ready;
    logic wr_take;

    always_comb
    begin
        next_w_state = w_state;
        next_w_cnt = w_cnt;
        next_w_pins = w_pins;
        wr_take = 1'b0;
        if (!running)
        begin
            next_w_state = W_IDLE;
            next_w_cnt = '0;
            next_w_pins.strobe = 1'b0;
        end
        else
        begin
            case (w_state)
                W_IDLE:
                begin
                    if (WR_VALID && WR_READY)
                    begin
                        wr_take = 1'b1;
                        next_w_pins.data = WR_DATA;
                        next_w_pins.strobe = 1'b1;
                        next_w_state = W_HIGH;
                        next_w_cnt = '0;
                    end
                end
                W_HIGH:
                begin
                    // strobe stays high past its minimum width until the word is taken
                    if (w_cnt != CNT_W'(SI_WIDTH_CYC - 1))
                    begin
                        next_w_cnt = w_cnt + 1'b1;
                    end
                    else if (!INPUT_READY)
                    begin
                        next_w_pins.strobe = 1'b0;
                        next_w_state = W_LOW;
                        next_w_cnt = '0;
                    end
                end
                default:
                begin
                    // keep data past the falling strobe and the strobe low its minimum
                    if (w_cnt == CNT_W'(DATA_HOLD_CYC - 1))
                    begin
                        next_w_state = W_IDLE;
                        next_w_cnt = '0;
                    end
                    else
                    begin
                        next_w_cnt = w_cnt + 1'b1;
                    end
                end
            endcase
        end
        // input-ready high again means the input stage is free
        // ready follows the next clear state so no word is accepted once a clear has started
        next_wr_ready = (next_c_state == C_RUN) && (next_w_state == W_IDLE) && INPUT_READY && !wr_take;
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            w_state <= W_IDLE;
            w_cnt <= '0;
            w_pins <= '0;
            WR_READY <= 1'b0;
        end
        else
        begin
            w_state <= next_w_state;
            w_cnt <= next_w_cnt;
            w_pins <= next_w_pins;
            WR_READY <= next_wr_ready;
        end
    end

    assign SHIFT_IN = w_pins.strobe;
    assign WRITE_WORD_IN = w_pins.data;

    // =====================================================
    // read strobe sequencer
    ffh_rstate_e r_state;
    ffh_rstate_e next_r_state;
    logic [CNT_W-1:0] r_cnt;
    logic [CNT_W-1:0] next_r_cnt;
    logic so;
    logic next_so;
    logic buf_in_valid;
    logic buf_in_ready;

    always_comb
    begin
        next_r_state = r_state;
        next_r_cnt = r_cnt;
        next_so = so;
        buf_in_valid = 1'b0;
        if (!running)
        begin
            next_r_state = R_IDLE;
            next_r_cnt = '0;
            next_so = 1'b0;
        end
        else
        begin
            case (r_state)
                R_IDLE:
                begin
                    // capture while the flag is high, then unload
                    if (OUTPUT_READY_FLAG && buf_in_ready)
                    begin
                        buf_in_valid = 1'b1;
                        next_so = 1'b1;
                        next_r_state = R_HIGH;
                        next_r_cnt = '0;
                    end
                end
                R_HIGH:
                begin
                    if (r_cnt != CNT_W'(SO_WIDTH_CYC - 1))
                    begin
                        next_r_cnt = r_cnt + 1'b1;
                    end
                    else if (!OUTPUT_READY_FLAG)
                    begin
                        next_so = 1'b0;
                        next_r_state = R_LOW;
                        next_r_cnt = '0;
                    end
                end
                default:
                begin
                    if (r_cnt == CNT_W'(SO_WIDTH_CYC - 1))
                    begin
                        next_r_state = R_IDLE;
                        next_r_cnt = '0;
                    end
                    else
                    begin
                        next_r_cnt = r_cnt + 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            r_state <= R_IDLE;
            r_cnt <= '0;
            so <= 1'b0;
        end
        else
        begin
            r_state <= next_r_state;
            r_cnt <= next_r_cnt;
            so <= next_so;
        end
    end

    assign SHIFT_OUT = so;

    // =====================================================
    // read data buffer; a stalled reader keeps the unload strobe from firing
    ffh_buf2 #(
        .W(W)
    ) u_rbuf (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(READ_WORD_OUT),
        .out_valid(RD_VALID),
        .out_ready(RD_READY),
        .out_data(RD_DATA)
    );

endmodule

// ==== tb/ffh_dev_model.sv ====
// behavioural model of the 64 x 9 fall-through fifo device
// assumes strobes change just after REF_CLK rises; slow delays flag rises
module ffh_dev_model
    import ffh_pkg::*;
(
    // clock and pacing
    input wire logic clk,
    input wire logic slow,
    // clear
    input wire logic master_clear_n,
    // input side
    input wire logic shift_in,
    input wire logic [WORD_W-1:0] write_word_in,
    output logic input_ready,
    // output side
    input wire logic shift_out,
    output logic output_ready_flag,
    output logic [WORD_W-1:0] read_word_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [WORD_W-1:0] mem[$];
    logic [WORD_W-1:0] head = '0;
    logic [1:0] tick = '0;
    logic go;
    logic si_done = 1'h0;
    // ====
    // flags and storage
    assign go = !slow || (tick == 2'h0);
    // stale word is inverted so a late sample never matches
    assign read_word_out = output_ready_flag ? head : ~head;
    always @(posedge clk)
    begin
        tick <= tick + 2'h1;
        if (!master_clear_n)
        begin
            mem.delete();
            si_done <= 1'h0;
            input_ready <= 1'h1;
            output_ready_flag <= 1'h0;
        end
        else
        begin
            if (shift_in && input_ready)
            begin
                mem.push_back(write_word_in);
                input_ready <= 1'h0;
                si_done <= 1'h1;
            end
            else
            begin
                // a held strobe that has not loaded yet is taken once space appears
                if (!shift_in)
                    si_done <= 1'h0;
                if ((!shift_in || !si_done) && go && mem.size() < FIFO_DEPTH)
                    input_ready <= 1'h1;
            end
            if (shift_out && output_ready_flag)
            begin
                void'(mem.pop_front());
                output_ready_flag <= 1'h0;
            end
            else if (!shift_out && !output_ready_flag && go && mem.size() > 0)
            begin
                head <= mem[0];
                output_ready_flag <= 1'h1;
            end
        end
    end
endmodule

// ==== tb/ffh_host_checker.sv ====
// concurrent checks on the ports of the fifo host controller
// bound into ffh_host; one clock domain
module ffh_host_checker
    import ffh_pkg::*;
#(
    parameter int W = WORD_W
)
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // user side
    input wire logic CLEAR_REQ,
    input wire logic CLEAR_BUSY,
    input wire logic WR_VALID,
    input wire logic WR_READY,
    input wire logic [W-1:0] WR_DATA,
    input wire logic RD_VALID,
    input wire logic RD_READY,
    input wire logic [W-1:0] RD_DATA,
    // device side
    input wire logic SHIFT_IN,
    input wire logic [W-1:0] WRITE_WORD_IN,
    input wire logic INPUT_READY,
    input wire logic SHIFT_OUT,
    input wire logic OUTPUT_READY_FLAG,
    input wire logic [W-1:0] READ_WORD_OUT,
    input wire logic MASTER_CLEAR_N
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);
    sequence s_clear_end;
        CLEAR_BUSY ##1 !CLEAR_BUSY;
    endsequence
    // ====
    // strobes
    a_si_release: assert property (SHIFT_IN && !INPUT_READY |=> !SHIFT_IN)
        else $error("shift-in not lowered");
    a_so_release: assert property (SHIFT_OUT && !OUTPUT_READY_FLAG |=> !SHIFT_OUT)
        else $error("shift-out not lowered");
    a_si_word: assert property ($rose(SHIFT_IN) |-> $past(WR_VALID && WR_READY) && WRITE_WORD_IN == $past(WR_DATA))
        else $error("shift-in without word");
    a_si_hold: assert property ($past(SHIFT_IN) |-> $stable(WRITE_WORD_IN))
        else $error("word moved under strobe");
    a_so_capture: assert property ($rose(SHIFT_OUT) |-> $past(OUTPUT_READY_FLAG) && RD_VALID)
        else $error("shift-out without capture");
    // ====
    // clear and flow
    a_clear_seq: assert property ($rose(MASTER_CLEAR_N) |-> s_clear_end)
        else $error("clear sequence wrong");
    a_wr_gate: assert property (WR_READY |-> !SHIFT_IN && !CLEAR_BUSY && MASTER_CLEAR_N)
        else $error("write ready during transfer");
    a_rd_hold: assert property (RD_VALID && !RD_READY && !CLEAR_REQ && !CLEAR_BUSY |=> RD_VALID && $stable(RD_DATA))
        else $error("read word lost");
endmodule

bind ffh_host ffh_host_checker #(.W(W)) u_checker (.REF_CLK(REF_CLK), .RST_N(RST_N), .CLEAR_REQ(CLEAR_REQ),
    .CLEAR_BUSY(CLEAR_BUSY), .WR_VALID(WR_VALID), .WR_READY(WR_READY), .WR_DATA(WR_DATA), .RD_VALID(RD_VALID),
    .RD_READY(RD_READY), .RD_DATA(RD_DATA), .SHIFT_IN(SHIFT_IN), .WRITE_WORD_IN(WRITE_WORD_IN),
    .INPUT_READY(INPUT_READY), .SHIFT_OUT(SHIFT_OUT), .OUTPUT_READY_FLAG(OUTPUT_READY_FLAG),
    .READ_WORD_OUT(READ_WORD_OUT), .MASTER_CLEAR_N(MASTER_CLEAR_N));

// ==== tb/tb_fall_through_fifo_handshake.sv ====
// self-checking bench for the fifo host controller
// drives the user side; the device model stands on the far side
module tb_fall_through_fifo_handshake
    import ffh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic slow; logic [WORD_W-1:0] word; logic [WORD_W-1:0] exp;} ffh_row_s;
    ffh_row_s rows[4] = '{'{1'h0, 9'h000, 9'h000}, '{1'h1, 9'h1ff, 9'h1ff}, '{1'h0, 9'h155, 9'h155},
        '{1'h1, 9'h0aa, 9'h0aa}};
    logic ref_clk = 1'h0, rst_n = 1'h0, clear_req = 1'h0, wr_valid = 1'h0, rd_ready = 1'h0, slow = 1'h0;
    logic [WORD_W-1:0] wr_data = '0;
    logic clear_busy, wr_ready, rd_valid, shift_in, input_ready, shift_out, oready, mclr_n;
    logic [WORD_W-1:0] rd_data, word_in, word_out;
    int miscompares = 0, compares = 0, cycles = 0;
    // ====
    // design and device
    ffh_host u_dut (.REF_CLK(ref_clk), .RST_N(rst_n), .CLEAR_REQ(clear_req), .CLEAR_BUSY(clear_busy),
        .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_DATA(wr_data), .RD_VALID(rd_valid), .RD_READY(rd_ready),
        .RD_DATA(rd_data), .SHIFT_IN(shift_in), .WRITE_WORD_IN(word_in), .INPUT_READY(input_ready),
        .SHIFT_OUT(shift_out), .OUTPUT_READY_FLAG(oready), .READ_WORD_OUT(word_out), .MASTER_CLEAR_N(mclr_n));
    ffh_dev_model u_dev (.clk(ref_clk), .slow(slow), .master_clear_n(mclr_n), .shift_in(shift_in),
        .write_word_in(word_in), .input_ready(input_ready), .shift_out(shift_out), .output_ready_flag(oready),
        .read_word_out(word_out));
    initial forever #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            finish_test();
        end
    end
    // ====
    // tasks
    task automatic check_bit(input string name, input logic exp, input logic act);
        compares++;
        if (act !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %b seen %b", name, exp, act);
        end
    endtask
    task automatic check_word(input string name, input logic [WORD_W-1:0] exp, input logic [WORD_W-1:0] act);
        compares++;
        if (act !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", name, exp, act);
        end
    endtask
    // wait bounded for a level, from just after an edge
    task automatic await(ref logic sig, input logic lvl);
        int n;
        n = 0;
        while (sig !== lvl && n < 400)
        begin
            @(posedge ref_clk) #1;
            n++;
        end
    endtask
    task automatic push(input logic [WORD_W-1:0] w);
        wr_valid = 1'h1;
        wr_data = w;
        await(wr_ready, 1'h1);
        check_bit("wr_ready", 1'h1, wr_ready);
        @(posedge ref_clk) #1;
        wr_valid = 1'h0;
        @(posedge ref_clk) #1;
    endtask
    task automatic pop(input logic [WORD_W-1:0] exp);
        await(rd_valid, 1'h1);
        check_word("rd_data", exp, rd_data);
        rd_ready = 1'h1;
        @(posedge ref_clk) #1;
        rd_ready = 1'h0;
        @(posedge ref_clk) #1;
    endtask
    task automatic finish_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ====
    // sequence
    initial
    begin
        repeat (16) @(posedge ref_clk);
        check_bit("mclr_n", 1'h0, mclr_n);
        #1 rst_n = 1'h1;
        repeat (3) @(posedge ref_clk) #1;
        await(clear_busy, 1'h0);
        check_bit("clear_busy", 1'h0, clear_busy);
        check_bit("input_ready", 1'h1, input_ready);
        check_bit("oready", 1'h0, oready);
        $display("reset test done");
        foreach (rows[i])
        begin
            slow = rows[i].slow;
            push(rows[i].word);
            push(~rows[i].word);
            pop(rows[i].exp);
            pop(~rows[i].exp);
        end
        $display("row test done");
        slow = 1'h0;
        for (int i = 0; i < 66; i++)
            push(9'(i * 7 + 3));
        fork
            push(9'h1a5);
            begin
                repeat (20) @(posedge ref_clk);
                #1 check_bit("wr_ready_full", 1'h0, wr_ready);
                for (int i = 0; i < 66; i++)
                    pop(9'(i * 7 + 3));
                pop(9'h1a5);
            end
        join
        repeat (8) @(posedge ref_clk) #1;
        check_bit("rd_valid_empty", 1'h0, rd_valid);
        check_bit("oready_empty", 1'h0, oready);
        $display("fill test done");
        for (int i = 0; i < 3; i++)
            push(9'h0f0 + 9'(i));
        clear_req = 1'h1;
        @(posedge ref_clk) #1;
        clear_req = 1'h0;
        repeat (3) @(posedge ref_clk) #1;
        await(clear_busy, 1'h0);
        check_bit("clear_busy_clr", 1'h0, clear_busy);
        check_bit("input_ready_clr", 1'h1, input_ready);
        check_bit("oready_clr", 1'h0, oready);
        $display("clear test done");
        finish_test();
    end
endmodule
